// ==== hw/cbp_pkg.sv ====
// Purpose: Shared constants for the processor-bus slave of the host bridge.
// Assumes: 20 MHz single clock, synchronous active-high reset.
// Notes: Register offsets are word addresses on the plain register port.
package cbp_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_MAPS = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int CMD_W = 46;
  localparam int CMD_DEPTH = 4;
  localparam int DATA_DEPTH = 8;
  localparam int PTR_W = 3;

  // ==========================================================
  // Register map (word offsets)
  localparam logic [3:0] REG_MAP_RANGE0 = 4'h0;   // Maps 0..3 at 0..3: start[31:16], end[15:0]
  localparam logic [3:0] REG_MAP_ATTR0 = 4'h4;    // Maps 0..3 at 4..7: offset[31:16], attr[7:0]
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [31:0] RANGE_RESET = 32'h0000_0000;
  localparam logic [31:0] ATTR_RESET = 32'h0000_0000;

  // Attribute bit positions
  localparam int ATTR_RD_EN = 0;
  localparam int ATTR_WR_EN = 1;
  localparam int ATTR_POST_EN = 2;
  localparam int ATTR_XFER_LO = 4;  // Two-bit PCI transfer characteristics
  localparam int ATTR_XFER_HI = 5;

  // ==========================================================
  // Transfer-type classes
  typedef enum logic [1:0] {CBP_NONE, CBP_AONLY, CBP_WRITE, CBP_READ} cbp_class_t;

  // Slave state machine
  typedef enum logic [2:0] {CBP_IDLE, CBP_CMD, CBP_DATA, CBP_WAIT_PCI, CBP_ACK} cbp_state_t;

endpackage

// ==== hw/cbp_slave.sv ====
// Purpose: Processor-bus slave of a host-to-PCI bridge with four map decoders.
// Assumes: One clock; bus pins sampled synchronously; PCI master drains queues.
// Notes: Command and data queues sit inside; acknowledges are active-high pulses.
//
// Operation
// - Compare upper 16 bits against four decoders
// - Decoder granularity is 64 KByte windows
// - Per-map read, write, posting, transfer attributes
// - PCI upper half is address plus offset
// - Compelled accesses acknowledged after PCI completion
// - Failed compelled access answered with retry
// - Burst writes always posted
// - Posted write with room acknowledged at once
// - Full queue holds address acknowledge back
// - Decoded address-only commands acknowledged immediately
// - Undecoded address-only commands ignored
// - Listed address-only encodings classified as such
// - Flush, kill, flush-atomic writes are writes
// - Listed read encodings classified as reads
// - External control and reserved encodings ignored
// - Commands and data pass through outbound queue
// - Processor reaches only processor-side registers
// - Boundary-crossing transfers may complete partially
`timescale 1ns/1ns
module cbp_slave
(
  input wire logic clk,                // 20 MHz clock
  input wire logic sys_rst,            // Synchronous reset, active high
  input wire logic [3:0] reg_addr,     // Register word address
  input wire logic [31:0] reg_wdata,   // Register write data
  input wire logic reg_wr,             // Register write strobe
  input wire logic reg_rd,             // Register read strobe
  output logic [31:0] reg_rdata,       // Read data, cycle after strobe
  input wire logic ts,                 // Transfer start pulse
  input wire logic [31:0] bus_addr,    // Processor address
  input wire logic [4:0] bus_tt,       // Transfer type
  input wire logic bus_burst,          // Four-beat burst
  input wire logic [63:0] bus_wdata,   // Write beat data
  output logic aack,                   // Address acknowledge pulse
  output logic ta,                     // Transfer acknowledge pulse
  output logic retry,                  // Retry pulse
  output logic [63:0] bus_rdata,       // Read beat data
  output logic cmd_valid,              // Command queue not empty
  input wire logic cmd_ready,          // PCI master takes command
  output logic [45:0] cmd_data,        // Command word
  output logic wdat_valid,             // Write data available
  input wire logic wdat_ready,         // PCI master takes write beat
  output logic [63:0] wdat_data,       // Write beat to PCI
  input wire logic rdat_valid,         // Read beat from PCI
  output logic rdat_ready,             // Room for read beat
  input wire logic [63:0] rdat_data,   // Read beat data from PCI
  input wire logic pci_done,           // Compelled access finished on PCI
  input wire logic pci_fail            // Compelled access failed on PCI
);

  // ==========================================================
  // Classification of transfer types
  function automatic cbp_pkg::cbp_class_t classify(input logic [4:0] tt);
    cbp_pkg::cbp_class_t c;
    c = cbp_pkg::CBP_NONE;
    // One line per encoding keeps the table easy to audit
    case (tt)
      5'h00: c = cbp_pkg::CBP_AONLY;  // Clean block
      5'h04: c = cbp_pkg::CBP_AONLY;  // Flush block
      5'h08: c = cbp_pkg::CBP_AONLY;  // Sync
      5'h0C: c = cbp_pkg::CBP_AONLY;  // Kill block
      5'h10: c = cbp_pkg::CBP_AONLY;  // Ordering barrier
      5'h18: c = cbp_pkg::CBP_AONLY;  // Translation invalidate
      5'h01: c = cbp_pkg::CBP_AONLY;  // Reserving load
      5'h05: c = cbp_pkg::CBP_AONLY;  // Conditional store
      5'h09: c = cbp_pkg::CBP_AONLY;  // Translation sync
      5'h0D: c = cbp_pkg::CBP_AONLY;  // Instruction block invalidate
      5'h02: c = cbp_pkg::CBP_WRITE;  // Write with flush
      5'h06: c = cbp_pkg::CBP_WRITE;  // Write with kill
      5'h12: c = cbp_pkg::CBP_WRITE;  // Write with flush, atomic
      5'h0A: c = cbp_pkg::CBP_READ;   // Read
      5'h0E: c = cbp_pkg::CBP_READ;   // Read with intent to modify
      5'h1A: c = cbp_pkg::CBP_READ;   // Read, atomic
      5'h1E: c = cbp_pkg::CBP_READ;   // Read with intent to modify, atomic
      5'h0B: c = cbp_pkg::CBP_READ;   // Read, no intent to cache
      5'h14: c = cbp_pkg::CBP_NONE;   // External control out
      5'h1C: c = cbp_pkg::CBP_NONE;   // External control in
      default: c = cbp_pkg::CBP_NONE; // Reserved encodings
    endcase
    return c;
  endfunction

  // ==========================================================
  // Map registers
  // Transfer fields are captured at start, so decoder writes made
  // during a transfer cannot move it to another window
  logic [31:0] range_q [cbp_pkg::NUM_MAPS];
  logic [31:0] attr_q [cbp_pkg::NUM_MAPS];
  cbp_pkg::cbp_state_t state_q;
  logic [3:0] hit_q;
  logic [1:0] map_q;
  logic is_write_q;
  logic burst_q;
  logic posted_q;
  logic [31:0] addr_q;
  logic [1:0] beat_q;
  logic [31:0] status_q;

  // Decoder hit per window, 64 KByte resolution on address[31:16]
  // Start and end are both inclusive. A zero range still matches the
  // lowest block; cleared attributes keep it from claiming reads and writes
  logic [3:0] hit;
  always_comb
  begin
    for (int i = 0; i < cbp_pkg::NUM_MAPS; i++)
      hit[i] = bus_addr[31:16] >= range_q[i][31:16] && bus_addr[31:16] <= range_q[i][15:0];
  end

  // Pick lowest hit; overlaps are software's problem
  // Lowest map wins only so that an overlap at least behaves
  // the same way every time
  logic [1:0] sel;
  always_comb
  begin
    sel = 2'd0;
    for (int i = cbp_pkg::NUM_MAPS - 1; i >= 0; i--)
      if (hit[i])
        sel = i[1:0];
  end

  wire cbp_pkg::cbp_class_t cls = classify(bus_tt);
  wire [31:0] sel_attr = attr_q[sel];
  wire any_hit = |hit;
  wire rd_ok = sel_attr[cbp_pkg::ATTR_RD_EN];
  wire wr_ok = sel_attr[cbp_pkg::ATTR_WR_EN];
  // Claim only enabled matching accesses
  wire claim_rw = any_hit && ((cls == cbp_pkg::CBP_READ && rd_ok) || (cls == cbp_pkg::CBP_WRITE && wr_ok));
  wire claim_ao = any_hit && cls == cbp_pkg::CBP_AONLY;
  // Burst writes always posted: no late retry point
  wire post_now = cls == cbp_pkg::CBP_WRITE && (bus_burst || sel_attr[cbp_pkg::ATTR_POST_EN]);
  // Offset sum wraps at the top of PCI space; no carry is kept
  wire [15:0] pci_hi = bus_addr[31:16] + sel_attr[31:16];

  // ==========================================================
  // Command queue
  logic [45:0] cq_mem [cbp_pkg::CMD_DEPTH];
  logic [2:0] cq_wp_q;
  logic [2:0] cq_rp_q;
  wire cq_full = (cq_wp_q[1:0] == cq_rp_q[1:0]) && (cq_wp_q[2] != cq_rp_q[2]);
  wire cq_empty = cq_wp_q == cq_rp_q;
  // Command word: write flag, burst, xfer attr, PCI address, pad
  wire [45:0] cmd_word = {is_write_q, burst_q, attr_q[map_q][cbp_pkg::ATTR_XFER_HI:cbp_pkg::ATTR_XFER_LO],
    addr_q, 10'h000};
  wire cq_pop = cmd_valid && cmd_ready;
  assign cmd_valid = !cq_empty;
  assign cmd_data = cq_mem[cq_rp_q[1:0]];

  // Data queue, shared by write and read beats
  // Direction follows the transfer in progress; a new transfer waits only for
  // room, so posted write beats can still be inside when a read starts
  logic [63:0] dq_mem [cbp_pkg::DATA_DEPTH];
  logic [3:0] dq_wp_q;
  logic [3:0] dq_rp_q;
  wire dq_full = (dq_wp_q[2:0] == dq_rp_q[2:0]) && (dq_wp_q[3] != dq_rp_q[3]);
  wire dq_empty = dq_wp_q == dq_rp_q;
  wire wbeat = state_q == cbp_pkg::CBP_DATA && is_write_q && !dq_full;
  wire rbeat_in = rdat_valid && rdat_ready;
  wire rbeat_out = state_q == cbp_pkg::CBP_DATA && !is_write_q && !dq_empty;
  wire wbeat_out = wdat_valid && wdat_ready;
  wire dq_push = wbeat || rbeat_in;
  wire dq_pop = rbeat_out || wbeat_out;
  assign rdat_ready = !is_write_q && !dq_full && state_q != cbp_pkg::CBP_IDLE;
  assign wdat_valid = !dq_empty && is_write_q;
  assign wdat_data = dq_mem[dq_rp_q[2:0]];

  // Both queues need room before the address is acknowledged; a burst
  // claims four data slots up front so it never stalls mid-burst
  wire [3:0] dq_level = dq_wp_q - dq_rp_q;
  wire [3:0] beats_need = burst_q ? 4'h4 : 4'h1;
  wire dq_room = dq_level <= 4'(cbp_pkg::DATA_DEPTH) - beats_need;
  wire cmd_go = state_q == cbp_pkg::CBP_CMD && !cq_full && dq_room;
  wire cq_push = cmd_go;
  // Read beats past the first are dropped when the read ends, so stale
  // read data never leaks out as write data of a later transfer
  wire rd_end = !is_write_q && (pci_done || pci_fail) &&
    (state_q == cbp_pkg::CBP_DATA || state_q == cbp_pkg::CBP_WAIT_PCI);

  // ==========================================================
  // Queue storage and pointers
  // Storage has no reset: only entries between the pointers are read.
  // Pointers carry one extra bit to tell full from empty.
  always_ff @(posedge clk)
  begin
    if (cq_push)
      cq_mem[cq_wp_q[1:0]] <= cmd_word;
    if (dq_push)
      dq_mem[dq_wp_q[2:0]] <= wbeat ? bus_wdata : rdat_data;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cq_wp_q <= 3'h0;
      cq_rp_q <= 3'h0;
      dq_wp_q <= 4'h0;
      dq_rp_q <= 4'h0;
    end
    else
    begin
      cq_wp_q <= cq_wp_q + 3'(cq_push);
      cq_rp_q <= cq_rp_q + 3'(cq_pop);
      dq_wp_q <= dq_wp_q + 4'(dq_push);
      dq_rp_q <= rd_end ? dq_wp_q : dq_rp_q + 4'(dq_pop);
    end
  end

  // ==========================================================
  // Slave sequencing
  // Posted writes: address acknowledge once the command is queued, then
  // one data acknowledge per beat as it enters the data queue.
  // Compelled reads and single writes: both acknowledges wait for the
  // PCI side, which removes any pipelining for those accesses.
  // A failed compelled access is answered with retry and nothing else.
  // Only one transfer is tracked; a start while busy is not seen.
  wire last_beat = !burst_q || beat_q == 2'd3;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= cbp_pkg::CBP_IDLE;
      aack <= 1'b0;
      ta <= 1'b0;
      retry <= 1'b0;
      bus_rdata <= 64'h0000_0000_0000_0000;
      hit_q <= 4'h0;
      map_q <= 2'd0;
      is_write_q <= 1'b0;
      burst_q <= 1'b0;
      posted_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      beat_q <= 2'd0;
    end
    else
    begin
      aack <= 1'b0;
      ta <= 1'b0;
      retry <= 1'b0;
      unique case (state_q)
        cbp_pkg::CBP_IDLE:
        begin
          if (ts && claim_ao)
            aack <= 1'b1;
          else if (ts && claim_rw)
          begin
            hit_q <= hit;
            map_q <= sel;
            is_write_q <= cls == cbp_pkg::CBP_WRITE;
            burst_q <= bus_burst;
            posted_q <= post_now;
            addr_q <= {pci_hi, bus_addr[15:0]};
            beat_q <= 2'd0;
            state_q <= cbp_pkg::CBP_CMD;
          end
        end
        cbp_pkg::CBP_CMD:
        begin
          // Wait states while either queue lacks room
          if (cmd_go)
          begin
            state_q <= cbp_pkg::CBP_DATA;
            if (posted_q)
              aack <= 1'b1;
          end
        end
        cbp_pkg::CBP_DATA:
        begin
          if (wbeat)
          begin
            beat_q <= beat_q + 2'd1;
            if (posted_q)
              ta <= 1'b1;
            if (last_beat)
              state_q <= posted_q ? cbp_pkg::CBP_IDLE : cbp_pkg::CBP_WAIT_PCI;
          end
          else if (rbeat_out)
          begin
            // Read data queued; released only after PCI done
            bus_rdata <= dq_mem[dq_rp_q[2:0]];
            // A single beat's completion can arrive with the beat itself;
            // missing it here would leave the processor waiting forever
            if (pci_fail)
            begin
              retry <= 1'b1;
              state_q <= cbp_pkg::CBP_IDLE;
            end
            else if (pci_done)
            begin
              aack <= 1'b1;
              ta <= 1'b1;
              state_q <= cbp_pkg::CBP_IDLE;
            end
            else
              state_q <= cbp_pkg::CBP_WAIT_PCI;
          end
          else if (!is_write_q && pci_fail)
          begin
            retry <= 1'b1;
            state_q <= cbp_pkg::CBP_IDLE;
          end
        end
        cbp_pkg::CBP_WAIT_PCI:
        begin
          if (pci_fail)
          begin
            retry <= 1'b1;
            state_q <= cbp_pkg::CBP_IDLE;
          end
          else if (pci_done)
          begin
            aack <= 1'b1;
            ta <= 1'b1;
            state_q <= cbp_pkg::CBP_IDLE;
          end
        end
        cbp_pkg::CBP_ACK:
          state_q <= cbp_pkg::CBP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Status word: state, queue levels, last hit
  // Rebuilt every cycle from live state, never stored
  always_comb
  begin
    status_q = {16'h0000, hit_q, 1'b0, 3'(state_q), cq_wp_q - cq_rp_q, 1'b0, dq_wp_q - dq_rp_q};
  end

  // Register port; processor side reaches only these
  // Decoder writes take effect at the next transfer start; the transfer
  // attributes in a command word are read when it is queued
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < cbp_pkg::NUM_MAPS; i++)
      begin
        range_q[i] <= cbp_pkg::RANGE_RESET;
        attr_q[i] <= cbp_pkg::ATTR_RESET;
      end
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr && reg_addr < cbp_pkg::REG_MAP_ATTR0)
        range_q[reg_addr[1:0]] <= reg_wdata;
      else if (reg_wr && reg_addr < cbp_pkg::REG_STATUS)
        attr_q[reg_addr[1:0]] <= reg_wdata;
      if (reg_rd)
      begin
        if (reg_addr < cbp_pkg::REG_MAP_ATTR0)
          reg_rdata <= range_q[reg_addr[1:0]];
        else if (reg_addr < cbp_pkg::REG_STATUS)
          reg_rdata <= attr_q[reg_addr[1:0]];
        else if (reg_addr == cbp_pkg::REG_STATUS)
          reg_rdata <= status_q;
        else
          reg_rdata <= 32'h0000_0000;  // Unmapped reads zero
      end
    end
  end

  // Partial completion on boundary crossing is accepted as-is
  // No beat count is kept per command, so a cut transfer is not resumed here

endmodule

// ==== verification/cbp_pci_model.sv ====
// Purpose: Behavioural PCI master draining the outbound queues.
// Assumes: mode 0 posts writes, 1 completes compelled ones, 2 fails them.
// Notes: One command at a time; stall freezes all intake.
`timescale 1ns/1ns
module cbp_pci_model
(
  input wire logic clk,                // Clock
  input wire logic sys_rst,            // Reset
  input wire logic cmd_valid,          // Command offered
  output logic cmd_ready,              // Command taken
  input wire logic [45:0] cmd_data,    // Command word
  input wire logic wdat_valid,         // Beat offered
  output logic wdat_ready,             // Beat taken
  input wire logic [63:0] wdat_data,   // Beat
  output logic rdat_valid,             // Read beat offered
  input wire logic rdat_ready,         // Read beat taken
  output logic [63:0] rdat_data,       // Read beat
  output logic pci_done,               // Finished
  output logic pci_fail,               // Failed
  input wire logic stall,              // Slow far side
  input wire logic [1:0] mode,         // Completion style
  output logic [45:0] last_cmd,        // Last command
  output logic [63:0] last_wdat        // Last beat
);
  logic [2:0] rd_left_q;
  logic wr_left_q;
  logic [31:0] addr_q;
  // Intake gating; idle read data is inverted so stale values never match
  assign cmd_ready = !stall && rd_left_q == 3'h0 && !wr_left_q;
  assign wdat_ready = !stall && (mode == 2'h0 || wr_left_q);
  assign rdat_valid = rd_left_q != 3'h0;
  assign rdat_data = rdat_valid ? {addr_q, 29'h0, rd_left_q} : ~{addr_q, 29'h0, rd_left_q};
  // Command, data and completion tracking
  always @(posedge clk)
  begin
    pci_done <= 1'b0;
    pci_fail <= 1'b0;
    if (sys_rst)
    begin
      rd_left_q <= 3'h0;
      wr_left_q <= 1'b0;
    end
    else
    begin
      if (cmd_valid && cmd_ready)
      begin
        last_cmd <= cmd_data;
        addr_q <= cmd_data[41:10];
        rd_left_q <= cmd_data[45] ? 3'h0 : (cmd_data[44] ? 3'h4 : 3'h1);
        wr_left_q <= cmd_data[45] && mode != 2'h0;
      end
      if (wdat_valid && wdat_ready)
        last_wdat <= wdat_data;
      if (wr_left_q && wdat_valid && wdat_ready)
      begin
        wr_left_q <= 1'b0;
        pci_done <= mode == 2'h1;
        pci_fail <= mode == 2'h2;
      end
      if (rdat_valid && rdat_ready)
        rd_left_q <= rd_left_q - 3'h1;
      if (rdat_valid && rdat_ready && rd_left_q == 3'h1)
      begin
        pci_done <= mode != 2'h2;
        pci_fail <= mode == 2'h2;
      end
    end
  end
endmodule

// ==== verification/cbp_slave_assertions.sv ====
// Purpose: Port checks for the processor-bus slave.
// Assumes: One clock, synchronous reset, one transfer at a time.
// Notes: Bound to every cbp_slave instance.
`timescale 1ns/1ns
module cbp_slave_assertions
(
  input wire logic clk,               // Clock
  input wire logic sys_rst,           // Reset
  input wire logic ts,                // Start
  input wire logic [4:0] bus_tt,      // Type
  input wire logic aack,              // Address ack
  input wire logic ta,                // Data ack
  input wire logic retry,             // Retry
  input wire logic cmd_valid,         // Command out
  input wire logic cmd_ready,         // Command taken
  input wire logic [45:0] cmd_data,   // Command word
  input wire logic wdat_valid,        // Beat out
  input wire logic wdat_ready,        // Beat taken
  input wire logic [63:0] wdat_data,  // Beat
  input wire logic pci_done,          // PCI finished
  input wire logic pci_fail           // PCI failed
);
  // ==========================================
  // Handshake and response checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A PCI done is followed next cycle by address and data ack together
  chk_done_ack: assert property (pci_done |=> aack && ta) else $error("no joint ack after done");
  chk_fail_retry: assert property (pci_fail |=> retry && !aack && !ta) else $error("no retry");
  chk_aack_pulse: assert property (aack |=> !aack) else $error("aack too long");
  chk_aonly_no_ta: assert property (ts && bus_tt inside {5'h00, 5'h08, 5'h10} |=> (!ta) [*4])
    else $error("ta on address-only");
  // No-response encodings must leave the bus silent
  chk_ecw_quiet: assert property (ts && bus_tt inside {5'h14, 5'h1c} |=> (!aack && !ta && !retry) [*4])
    else $error("answer to control word");
  chk_resv_quiet: assert property (ts && bus_tt[4] && bus_tt[0] |=> (!aack && !ta) [*4])
    else $error("answer to reserved type");
  chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("command dropped");
  chk_wdat_hold: assert property (wdat_valid && !wdat_ready |=> wdat_valid && $stable(wdat_data))
    else $error("write beat dropped");
endmodule
bind cbp_slave cbp_slave_assertions u_chk (.clk, .sys_rst, .ts, .bus_tt, .aack, .ta, .retry, .cmd_valid,
  .cmd_ready, .cmd_data, .wdat_valid, .wdat_ready, .wdat_data, .pci_done, .pci_fail);

// ==== verification/test_cbp_slave.sv ====
// Purpose: Self-checking bench for the processor-bus slave.
// Assumes: Far side is cbp_pci_model.
// Notes: Each transfer is judged by ack counts over a fixed window.
`timescale 1ns/1ns
module test_cbp_slave;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ts = 0, bus_burst = 0, stall = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, bus_addr = 32'h0, r;
  logic [4:0] bus_tt = 5'h0;
  logic [1:0] mode = 2'h0;
  logic [63:0] bus_wdata = 64'h0123_4567_89ab_cdef, bus_rdata, rdat_data, wdat_data, last_wdat, rd;
  logic aack, ta, retry, cmd_valid, cmd_ready, wdat_valid, wdat_ready, rdat_valid, rdat_ready, pci_done, pci_fail;
  logic [45:0] cmd_data, last_cmd;
  int failures = 0, n_checks = 0, na, nt, nr, nb, fa;
  cbp_slave u_cbp_slave (.*);
  cbp_pci_model u_cbp_pci_model (.*);
  // ==========================================
  // Clock and helpers
  initial
    forever #25 clk = ~clk;
  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task reg_acc(input logic [3:0] a, input logic [31:0] d, input logic wr);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
    @(posedge clk);
  endtask
  // One transfer, then count answers over a bounded window
  task run(input logic [31:0] a, input logic [4:0] t, input logic b);
    {na, nt, nr, nb, fa} = '0;
    bus_addr <= a;
    bus_tt <= t;
    bus_burst <= b;
    ts <= 1'b1;
    @(posedge clk);
    ts <= 1'b0;
    for (int i = 1; i <= 20; i++)
    begin
      @(negedge clk);
      fa = (aack && na == 0) ? i : fa;
      na += aack;
      nt += ta;
      nr += retry;
      nb += aack && ta;
      rd = ta ? bus_rdata : rd;
    end
    @(posedge clk);
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    reg_acc(cbp_pkg::REG_MAP_RANGE0, 32'h0, 1'b0);
    check("range0 reset", r, cbp_pkg::RANGE_RESET);
    // Distinct windows at 0x1000-0x10ff, 0x4000, 0x6000
    reg_acc(4'h0, 32'h1000_10ff, 1'b1);
    reg_acc(4'h1, 32'h4000_4000, 1'b1);
    reg_acc(4'h2, 32'h6000_6000, 1'b1);
    reg_acc(4'h4, 32'h2000_0027, 1'b1);
    reg_acc(4'h5, 32'h0000_0003, 1'b1);
    reg_acc(4'h6, 32'h0000_0001, 1'b1);
    reg_acc(cbp_pkg::REG_MAP_ATTR0, 32'h0, 1'b0);
    check("attr0 readback", r, 32'h2000_0027);
    reg_acc(4'hf, 32'h0, 1'b0);
    check("unmapped register", r, 32'h0);
    $display("register test done");
  endtask
  task t_codes;
    logic [6:0] tbl [24] = '{7'h20, 7'h24, 7'h28, 7'h2c, 7'h30, 7'h38, 7'h21, 7'h25, 7'h29, 7'h2d, 7'h42, 7'h46,
      7'h52, 7'h6a, 7'h6e, 7'h7a, 7'h7e, 7'h6b, 7'h14, 7'h1c, 7'h11, 7'h16, 7'h03, 7'h1f};
    mode <= 2'h0;
    foreach (tbl[i])
    begin
      run(32'h1000_0008, tbl[i][4:0], 1'b0);
      check("aack count", na, tbl[i][6:5] != 2'h0);
      check("ta count", nt, tbl[i][6]);
      if (tbl[i][6:5] != 2'h0)
        check("aack lag", fa, tbl[i][6:5] == 2'h1 ? 1 : (tbl[i][6:5] == 2'h2 ? 2 : fa));
      if (tbl[i][6:5] == 2'h3)
        check("read data", rd, {32'h3000_0008, 32'h1});
    end
    $display("type code test done");
  endtask
  task t_burst;
    run(32'h4000_0020, 5'h06, 1'b1);
    check("burst beats", nt, 4);
    check("burst aack lag", fa, 2);
    check("burst cmd", last_cmd, {4'b1100, 32'h4000_0020, 10'h0});
    check("burst data", last_wdat, bus_wdata);
    $display("burst test done");
  endtask
  task t_compelled;
    mode <= 2'h1;
    run(32'h4000_0010, 5'h02, 1'b0);
    check("joint ack", nb, 1);
    check("compelled cmd", last_cmd, {4'b1000, 32'h4000_0010, 10'h0});
    mode <= 2'h2;
    run(32'h1000_0008, 5'h0a, 1'b0);
    check("retry count", nr, 1);
    check("acks on retry", na + nt, 0);
    mode <= 2'h0;
    run(32'h6000_0000, 5'h02, 1'b0);
    check("write to read-only map", na, 0);
    run(32'h5000_0000, 5'h0a, 1'b0);
    check("read unmapped", na, 0);
    run(32'h5000_0000, 5'h08, 1'b0);
    check("sync unmapped", na, 0);
    $display("compelled and unclaimed test done");
  endtask
  task t_full;
    stall <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      run(32'h1000_0100 + 32'(i * 8), 5'h02, 1'b0);
      check("posted while stalled", na, i < 4);
    end
    stall <= 1'b0;
    for (int k = 0; k < 40 && aack !== 1'b1; k++)
      @(negedge clk);
    check("aack after room", aack, 1'b1);
    if (aack !== 1'b1)
      close_out;
    repeat (20) @(posedge clk);
    $display("full queue test done");
  endtask
  task close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_codes;
    t_burst;
    t_compelled;
    t_full;
    close_out;
  end
endmodule
